/* File: verilog/csr_pkg.sv */
package csr_pkg;

    // ========================================================================
    // Register offsets.
    // ========================================================================
    localparam logic [6:0] CSR_OFS_IND0     = 7'h00;
    localparam logic [6:0] CSR_OFS_IND1     = 7'h01;
    localparam logic [6:0] CSR_OFS_PCLO     = 7'h02;
    localparam logic [6:0] CSR_OFS_FLAGS    = 7'h03;
    localparam logic [6:0] CSR_OFS_PTR0_LO  = 7'h04;
    localparam logic [6:0] CSR_OFS_PTR0_HI  = 7'h05;
    localparam logic [6:0] CSR_OFS_PTR1_LO  = 7'h06;
    localparam logic [6:0] CSR_OFS_PTR1_HI  = 7'h07;
    localparam logic [6:0] CSR_OFS_BANK     = 7'h08;
    localparam logic [6:0] CSR_OFS_WORKING_REG     = 7'h09;
    localparam logic [6:0] CSR_OFS_PCHI     = 7'h0A;

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int         CSR_BIT_WDOG     = 4;
    localparam int         CSR_BIT_SLEEP    = 3;
    localparam int         CSR_BIT_ZERO     = 2;
    localparam int         CSR_BIT_HALF     = 1;
    localparam int         CSR_BIT_CARRY    = 0;
    localparam logic [7:0] CSR_BANK_MASK    = 8'h3F;
    localparam logic [7:0] CSR_PCHI_MASK    = 8'h7F;
    localparam logic [7:0] CSR_FLAGS_MASK   = 8'h1F;
    localparam logic [15:0] CSR_PTR_RST     = 16'h0000;
    localparam logic [7:0] CSR_BYTE_RST     = 8'h00;
    localparam int         CSR_PGM_BIT      = 15;

    // ========================================================================
    // Operations issued by the core.
    // ========================================================================
    typedef enum logic [3:0] {
        CSR_OP_NONE  = 4'h0,
        CSR_OP_ADD   = 4'h1,
        CSR_OP_SUB   = 4'h2,
        CSR_OP_AND   = 4'h3,
        CSR_OP_OR    = 4'h4,
        CSR_OP_XOR   = 4'h5,
        CSR_OP_RRC   = 4'h6,
        CSR_OP_RLC   = 4'h7,
        CSR_OP_MOVE  = 4'h8
    } csr_op_t;

endpackage : csr_pkg

/* File: verilog/csr_core_regs.sv */
// Overview of operation
// - Watchdog flag set by power-up/clear/sleep, cleared by timeout
// - Sleep flag set by power-up/clear, cleared by sleep
// - Full power reset forces both status flags high
// - Zero flag follows zero result
// - Arithmetic flags cleared on full power reset only
// - Half flag is carry from bit three
// - Carry flag is carry from top bit
// - Subtract adds two's complement, carry means no borrow
// - Rotates load carry with shifted-out bit
// - Pointer 0 sixteen bits, reset zero, addresses data 0
// - Pointer 1 sixteen bits, reset zero, addresses data 1
// - Pointers accessible as high and low bytes
// - Bank select six bits, forms upper direct address
// - Memory reached directly with bank or via pointers
// - Program counter high latch holds seven bits
// - Indirect access redirected to pointer's address
// - Pointer at indirect registers reads zero, drops writes
// - Pointer top bit selects program memory, read-only, slower
// - Stack push or pop leaves high latch alone
module csr_core_regs
    import csr_pkg::*;
(
    // Clock and resets.
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        power_rst_in,
    // Core register port, one access per cycle.
    input  wire logic [6:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    // Indirect slot select for data access.
    input  wire logic        ind_sel_in,
    // Arithmetic request.
    input  wire logic [3:0]  alu_op_in,
    input  wire logic [7:0]  alu_src_in,
    input  wire logic        alu_to_working_reg_in,
    output logic      [7:0]  alu_result_out,
    // Core events.
    input  wire logic        wdog_clear_in,
    input  wire logic        sleep_exec_in,
    input  wire logic        wdog_timeout_in,
    input  wire logic        stack_move_in,
    // Direct address and memory side.
    input  wire logic [6:0]  dir_offset_in,
    output logic      [12:0] dir_addr_out,
    output logic      [15:0] mem_addr_out,
    output logic             mem_pgm_out,
    output logic             mem_rd_out,
    output logic             mem_wr_out,
    output logic      [7:0]  mem_wdata_out,
    output logic             extra_cycle_out,
    input  wire logic [7:0]  mem_rdata_in
);

    // ========================================================================
    // State.
    // ========================================================================
    typedef struct packed {
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [5:0]  bank;
        logic [7:0]  working_reg;
        logic [6:0]  pchi;
        logic [7:0]  pclo;
        logic        wdog;
        logic        sleep;
        logic        zero;
        logic        half;
        logic        carry;
        logic [7:0]  rdata;
        logic [7:0]  result;
        logic [12:0] dir_addr;
        logic [15:0] mem_addr;
        logic        mem_pgm;
        logic        mem_rd;
        logic        mem_wr;
        logic [7:0]  mem_wdata;
        logic        extra;
    } csr_state_t;

    csr_state_t st_reg;
    csr_state_t st_next;

    function automatic logic is_ind_addr(input logic [15:0] a);
        return a[15:1] == 15'h0000;
    endfunction : is_ind_addr

    function automatic logic [8:0] add9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       ci);
        return {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : add9

    logic [15:0] ptr_sel;
    logic [7:0]  opb;
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic        ind_acc;

    always_comb begin
        st_next          = st_reg;
        ptr_sel          = ind_sel_in ? st_reg.ptr1 : st_reg.ptr0;
        ind_acc          = (reg_addr_in == CSR_OFS_IND0)
                         || (reg_addr_in == CSR_OFS_IND1);
        // Subtraction adds the two's complement of the source operand.
        opb              = (alu_op_in == CSR_OP_SUB) ? ~alu_src_in
                                                     : alu_src_in;
        sum              = add9(st_reg.working_reg, opb,
                                alu_op_in == CSR_OP_SUB);
        nib              = {1'b0, st_reg.working_reg[3:0]} + {1'b0, opb[3:0]}
                         + {4'h0, alu_op_in == CSR_OP_SUB};
        st_next.mem_rd   = 1'b0;
        st_next.mem_wr   = 1'b0;
        st_next.extra    = 1'b0;
        st_next.rdata    = CSR_BYTE_RST;
        st_next.dir_addr = {st_reg.bank, dir_offset_in};

        // Register reads; unimplemented bits read zero.
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                CSR_OFS_IND0, CSR_OFS_IND1:
                    st_next.rdata = is_ind_addr(ptr_sel) ? CSR_BYTE_RST
                                  : mem_rdata_in;
                CSR_OFS_PCLO:    st_next.rdata = st_reg.pclo;
                CSR_OFS_FLAGS:   st_next.rdata = {3'b000, st_reg.wdog,
                                    st_reg.sleep, st_reg.zero,
                                    st_reg.half, st_reg.carry};
                CSR_OFS_PTR0_LO: st_next.rdata = st_reg.ptr0[7:0];
                CSR_OFS_PTR0_HI: st_next.rdata = st_reg.ptr0[15:8];
                CSR_OFS_PTR1_LO: st_next.rdata = st_reg.ptr1[7:0];
                CSR_OFS_PTR1_HI: st_next.rdata = st_reg.ptr1[15:8];
                CSR_OFS_BANK:    st_next.rdata = {2'b00, st_reg.bank};
                CSR_OFS_WORKING_REG:    st_next.rdata = st_reg.working_reg;
                CSR_OFS_PCHI:    st_next.rdata = {1'b0, st_reg.pchi};
                default:         st_next.rdata = CSR_BYTE_RST;
            endcase
        end

        // Indirect data access goes to the pointed location.
        if (ind_acc && (reg_rd_in || reg_wr_in)) begin
            st_next.extra     = ptr_sel[CSR_PGM_BIT];
            st_next.mem_rd    = reg_rd_in && !is_ind_addr(ptr_sel);
            // Program memory is read-only; self-pointing writes are dropped.
            st_next.mem_wr    = reg_wr_in && !is_ind_addr(ptr_sel)
                              && !ptr_sel[CSR_PGM_BIT];
            st_next.mem_wdata = reg_wdata_in;
        end

        // Register writes.
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                CSR_OFS_PCLO:    st_next.pclo = reg_wdata_in;
                CSR_OFS_FLAGS:   {st_next.zero, st_next.half,
                                  st_next.carry} = reg_wdata_in[2:0];
                CSR_OFS_PTR0_LO: st_next.ptr0[7:0]  = reg_wdata_in;
                CSR_OFS_PTR0_HI: st_next.ptr0[15:8] = reg_wdata_in;
                CSR_OFS_PTR1_LO: st_next.ptr1[7:0]  = reg_wdata_in;
                CSR_OFS_PTR1_HI: st_next.ptr1[15:8] = reg_wdata_in;
                CSR_OFS_BANK:    st_next.bank = reg_wdata_in[5:0];
                CSR_OFS_WORKING_REG:    st_next.working_reg = reg_wdata_in;
                CSR_OFS_PCHI:    st_next.pchi = reg_wdata_in[6:0];
                default:         st_next.pclo = st_reg.pclo;
            endcase
        end

        // The memory address tracks the selected pointer every cycle, so an
        // indirect read sees the data of the pointer as it stands now.
        st_next.mem_addr = ind_sel_in ? st_next.ptr1 : st_next.ptr0;
        st_next.mem_pgm  = st_next.mem_addr[CSR_PGM_BIT];

        // Arithmetic and logic; the ALU wins over a same-cycle flag write.
        unique case (alu_op_in)
            CSR_OP_ADD, CSR_OP_SUB: begin
                st_next.result = sum[7:0];
                st_next.half   = nib[4];
                st_next.carry  = sum[8];
            end
            CSR_OP_AND:  st_next.result = st_reg.working_reg & alu_src_in;
            CSR_OP_OR:   st_next.result = st_reg.working_reg | alu_src_in;
            CSR_OP_XOR:  st_next.result = st_reg.working_reg ^ alu_src_in;
            CSR_OP_RRC: begin
                st_next.result = {st_reg.carry, alu_src_in[7:1]};
                st_next.carry  = alu_src_in[0];
            end
            CSR_OP_RLC: begin
                st_next.result = {alu_src_in[6:0], st_reg.carry};
                st_next.carry  = alu_src_in[7];
            end
            CSR_OP_MOVE: st_next.result = alu_src_in;
            default:     st_next.result = st_reg.result;
        endcase
        if (alu_op_in inside {CSR_OP_ADD, CSR_OP_SUB, CSR_OP_AND,
                              CSR_OP_OR, CSR_OP_XOR, CSR_OP_MOVE}) begin
            st_next.zero = (st_next.result == 8'h00);
        end
        if (alu_op_in != CSR_OP_NONE && alu_to_working_reg_in) begin
            st_next.working_reg = st_next.result;
        end

        // Stack moves never touch the high latch.
        if (stack_move_in) begin
            st_next.pchi = st_next.pchi;
        end

        // Power and watchdog status; timeout has priority over clear.
        if (wdog_clear_in) begin
            st_next.wdog  = 1'b1;
            st_next.sleep = 1'b1;
        end
        if (sleep_exec_in) begin
            st_next.wdog  = 1'b1;
            st_next.sleep = 1'b0;
        end
        if (wdog_timeout_in) begin
            st_next.wdog  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in && power_rst_in) begin
            st_reg          <= '0;
            st_reg.wdog     <= 1'b1;
            st_reg.sleep    <= 1'b1;
            st_reg.ptr0     <= CSR_PTR_RST;
            st_reg.ptr1     <= CSR_PTR_RST;
        end else if (!nrst_in) begin
            // Other resets keep arithmetic and power status.
            st_reg.ptr0     <= CSR_PTR_RST;
            st_reg.ptr1     <= CSR_PTR_RST;
            st_reg.bank     <= 6'h00;
            st_reg.working_reg     <= CSR_BYTE_RST;
            st_reg.pchi     <= 7'h00;
            st_reg.pclo     <= CSR_BYTE_RST;
            st_reg.rdata    <= CSR_BYTE_RST;
            st_reg.mem_rd   <= 1'b0;
            st_reg.mem_wr   <= 1'b0;
            st_reg.extra    <= 1'b0;
            st_reg.wdog     <= st_reg.wdog;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out   = st_reg.rdata;
    assign alu_result_out  = st_reg.result;
    assign dir_addr_out    = st_reg.dir_addr;
    assign mem_addr_out    = st_reg.mem_addr;
    assign mem_pgm_out     = st_reg.mem_pgm;
    assign mem_rd_out      = st_reg.mem_rd;
    assign mem_wr_out      = st_reg.mem_wr;
    assign mem_wdata_out   = st_reg.mem_wdata;
    assign extra_cycle_out = st_reg.extra;

    // ========================================================================
    // Checks.
    // ========================================================================
    a_sleep_clears: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sleep_exec_in && !wdog_timeout_in |=> !st_reg.sleep && st_reg.wdog)
        else $error("sleep flags wrong");
    a_timeout_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wdog_timeout_in |=> !st_reg.wdog)
        else $error("watchdog flag not cleared");
    a_power_reset: assert property (@(posedge sys_clk_in)
        !nrst_in && power_rst_in |=> st_reg.wdog && st_reg.sleep && !st_reg.carry
        && !st_reg.zero && !st_reg.half)
        else $error("power reset state wrong");
    a_add_carry: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        alu_op_in == CSR_OP_ADD |=> st_reg.carry == ({1'b0, $past(st_reg.working_reg)}
        + {1'b0, $past(alu_src_in)} > 9'h0FF))
        else $error("add carry wrong");
    a_sub_borrow: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        alu_op_in == CSR_OP_SUB |=> st_reg.carry == ($past(st_reg.working_reg)
        >= $past(alu_src_in)))
        else $error("subtract borrow wrong");
    a_zero_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        alu_op_in == CSR_OP_AND |=> st_reg.zero == (alu_result_out == 8'h00))
        else $error("zero flag wrong");
    a_rotate_right: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        alu_op_in == CSR_OP_RRC |=> st_reg.carry == $past(alu_src_in[0]))
        else $error("rotate carry wrong");
    a_self_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        reg_wr_in && reg_addr_in == CSR_OFS_IND0 && !ind_sel_in
        && is_ind_addr(st_reg.ptr0) |=> !mem_wr_out)
        else $error("self-pointing write not dropped");
    a_pgm_readonly: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        mem_pgm_out && extra_cycle_out |-> !mem_wr_out)
        else $error("program memory written");
    a_bank_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == CSR_OFS_BANK |=> reg_rdata_out[7:6] == 2'b00)
        else $error("bank high bits not zero");

endmodule : csr_core_regs

/* File: tb/csr_mem_model.sv */
module csr_mem_model (
    // Clock.
    input  wire logic        sys_clk_in,
    // Memory side of the register block.
    input  wire logic [15:0] mem_addr_in,
    input  wire logic        mem_pgm_in,
    input  wire logic        mem_wr_in,
    input  wire logic [7:0]  mem_wdata_in,
    output logic      [7:0]  mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] data_mem [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            data_mem[i] = 8'h00;
        end
    end

    // Program space answers with a pattern of its address so reads differ.
    always_comb begin
        mem_rdata_out = mem_pgm_in ? (mem_addr_in[7:0] ^ 8'hC3)
                                   : data_mem[mem_addr_in[7:0]];
    end

    always @(posedge sys_clk_in) begin
        if (mem_wr_in) begin
            data_mem[mem_addr_in[7:0]] <= mem_wdata_in;
        end
    end
endmodule : csr_mem_model

/* File: tb/tb.sv */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import csr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk_in, nrst_in, power_rst_in, reg_wr_in, reg_rd_in;
    logic [6:0]  reg_addr_in, dir_offset_in;
    logic [7:0]  reg_wdata_in, reg_rdata_out, alu_src_in, alu_result_out;
    logic [3:0]  alu_op_in;
    logic        ind_sel_in, alu_to_working_reg_in, wdog_clear_in, sleep_exec_in;
    logic        wdog_timeout_in, stack_move_in, mem_pgm_out, mem_rd_out;
    logic        mem_wr_out, extra_cycle_out;
    logic [12:0] dir_addr_out;
    logic [15:0] mem_addr_out;
    logic [7:0]  mem_wdata_out, mem_rdata_in, v;
    logic        wr_seen, pgm_seen, extra_seen;
    logic [15:0] addr_seen;
    logic [7:0]  wdata_seen;
    int          errors, compares;

    csr_core_regs u_csr_core_regs (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .power_rst_in(power_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .ind_sel_in(ind_sel_in), .alu_op_in(alu_op_in),
        .alu_src_in(alu_src_in), .alu_to_working_reg_in(alu_to_working_reg_in),
        .alu_result_out(alu_result_out), .wdog_clear_in(wdog_clear_in),
        .sleep_exec_in(sleep_exec_in), .wdog_timeout_in(wdog_timeout_in),
        .stack_move_in(stack_move_in), .dir_offset_in(dir_offset_in),
        .dir_addr_out(dir_addr_out), .mem_addr_out(mem_addr_out),
        .mem_pgm_out(mem_pgm_out), .mem_rd_out(mem_rd_out),
        .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
        .extra_cycle_out(extra_cycle_out), .mem_rdata_in(mem_rdata_in));

    csr_mem_model u_csr_mem_model (.sys_clk_in(sys_clk_in),
        .mem_addr_in(mem_addr_out), .mem_pgm_in(mem_pgm_out),
        .mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out),
        .mem_rdata_out(mem_rdata_in));

    always #20 sys_clk_in = ~sys_clk_in;

    // ========================================================================
    // Bus tasks: requests start at a falling edge, answers are taken one
    // cycle later at the next falling edge.
    // ========================================================================
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
        wr_seen = mem_wr_out;
        addr_seen = mem_addr_out;
        wdata_seen = mem_wdata_out;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
        pgm_seen = mem_pgm_out;
        extra_seen = extra_cycle_out;
    endtask : rd

    task automatic alu(input csr_op_t op, input logic [7:0] s);
        @(negedge sys_clk_in);
        alu_op_in = op;
        alu_src_in = s;
        @(negedge sys_clk_in);
        alu_op_in = CSR_OP_NONE;
    endtask : alu

    task automatic ev(input int k);
        @(negedge sys_clk_in);
        {wdog_timeout_in, sleep_exec_in, wdog_clear_in, stack_move_in} =
            4'(1 << k);
        @(negedge sys_clk_in);
        {wdog_timeout_in, sleep_exec_in, wdog_clear_in, stack_move_in} = 4'h0;
    endtask : ev

    task automatic do_reset(input logic p);
        @(negedge sys_clk_in);
        nrst_in = 1'b0;
        power_rst_in = p;
        repeat (3) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        power_rst_in = 1'b0;
    endtask : do_reset

    // ========================================================================
    // Scenarios.
    // ========================================================================
    task automatic t_regs();
        rd(CSR_OFS_FLAGS, v);  `CHK(v, 8'h18)
        rd(CSR_OFS_PTR0_HI, v); `CHK(v, 8'h00)
        rd(CSR_OFS_PTR1_LO, v); `CHK(v, 8'h00)
        rd(CSR_OFS_WORKING_REG, v);   `CHK(v, 8'h00)
        wr(CSR_OFS_BANK, 8'hFF); rd(CSR_OFS_BANK, v); `CHK(v, 8'h3F)
        wr(CSR_OFS_PCHI, 8'hFF); rd(CSR_OFS_PCHI, v); `CHK(v, 8'h7F)
        wr(CSR_OFS_PCHI, 8'h55); ev(0);
        rd(CSR_OFS_PCHI, v); `CHK(v, 8'h55)
        for (int i = 4; i < 8; i++) wr(7'(i), 8'(8'hA0 + i));
        for (int i = 4; i < 8; i++) begin
            rd(7'(i), v); `CHK(v, 8'(8'hA0 + i))
        end
        wr(CSR_OFS_BANK, 8'h15);
        @(negedge sys_clk_in);
        dir_offset_in = 7'h2A;
        @(negedge sys_clk_in);
        `CHK(dir_addr_out, {6'h15, 7'h2A})
    endtask : t_regs

    task automatic t_alu();
        wr(CSR_OFS_WORKING_REG, 8'h0F); alu(CSR_OP_ADD, 8'h01);
        `CHK(alu_result_out, 8'h10)
        rd(CSR_OFS_FLAGS, v); `CHK(v, 8'h1A)
        wr(CSR_OFS_WORKING_REG, 8'h10); alu(CSR_OP_SUB, 8'h10);
        rd(CSR_OFS_FLAGS, v); `CHK(v, 8'h1F)
        wr(CSR_OFS_WORKING_REG, 8'h81); alu(CSR_OP_RRC, 8'h81);
        `CHK(alu_result_out, 8'hC0)
        wr(CSR_OFS_WORKING_REG, 8'hF0); alu(CSR_OP_AND, 8'h0F);
        rd(CSR_OFS_FLAGS, v); `CHK(v[2], 1'b1)
        alu(CSR_OP_OR, 8'h0F); `CHK(alu_result_out, 8'hFF)
        rd(CSR_OFS_FLAGS, v); `CHK(v[2], 1'b0)
        alu_to_working_reg_in = 1'b1;
        alu(CSR_OP_ADD, 8'h10); alu_to_working_reg_in = 1'b0;
        rd(CSR_OFS_FLAGS, v); `CHK(v, 8'h1D)
        rd(CSR_OFS_WORKING_REG, v); `CHK(v, 8'h00)
        wr(CSR_OFS_WORKING_REG, 8'h00); alu(CSR_OP_XOR, 8'h00);
        rd(CSR_OFS_FLAGS, v); `CHK(v[2], 1'b1)
        wr(CSR_OFS_WORKING_REG, 8'h80); alu(CSR_OP_ADD, 8'h01);
        `CHK(alu_result_out, 8'h81)
        alu(CSR_OP_RLC, 8'h80); `CHK(alu_result_out, 8'h00)
        rd(CSR_OFS_FLAGS, v); `CHK(v[0], 1'b1)
    endtask : t_alu

    task automatic t_events();
        ev(3); rd(CSR_OFS_FLAGS, v); `CHK(v[4:3], 2'b01)
        ev(2); rd(CSR_OFS_FLAGS, v); `CHK(v[4:3], 2'b10)
        ev(1); rd(CSR_OFS_FLAGS, v); `CHK(v[4:3], 2'b11)
        wr(CSR_OFS_WORKING_REG, 8'hF0); alu(CSR_OP_ADD, 8'h10); ev(3);
        do_reset(1'b0);
        rd(CSR_OFS_FLAGS, v); `CHK(v, 8'h0D)
        rd(CSR_OFS_WORKING_REG, v); `CHK(v, 8'h00)
        do_reset(1'b1);
        rd(CSR_OFS_FLAGS, v); `CHK(v, 8'h18)
    endtask : t_events

    task automatic t_indirect();
        wr(CSR_OFS_PTR0_LO, 8'h23); wr(CSR_OFS_PTR0_HI, 8'h01);
        ind_sel_in = 1'b0;
        wr(CSR_OFS_IND0, 8'h5A);
        `CHK({wr_seen, addr_seen, wdata_seen}, {1'b1, 16'h0123, 8'h5A})
        rd(CSR_OFS_IND0, v); `CHK(v, 8'h5A)
        wr(CSR_OFS_PTR1_LO, 8'h01); wr(CSR_OFS_PTR1_HI, 8'h00);
        ind_sel_in = 1'b1;
        wr(CSR_OFS_IND1, 8'h77); `CHK(wr_seen, 1'b0)
        rd(CSR_OFS_IND1, v); `CHK(v, 8'h00)
        wr(CSR_OFS_PTR1_LO, 8'h05); wr(CSR_OFS_PTR1_HI, 8'h80);
        rd(CSR_OFS_IND1, v); `CHK({pgm_seen, extra_seen}, 2'b11)
        rd(CSR_OFS_IND1, v); `CHK(v, 8'hC6)
        wr(CSR_OFS_IND1, 8'h11); `CHK(wr_seen, 1'b0)
    endtask : t_indirect

    task automatic complete_run();
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        {sys_clk_in, nrst_in, power_rst_in, reg_wr_in, reg_rd_in} = 5'b00100;
        {ind_sel_in, alu_to_working_reg_in, wdog_clear_in, sleep_exec_in} = 4'h0;
        {wdog_timeout_in, stack_move_in} = 2'b00;
        {reg_addr_in, dir_offset_in, reg_wdata_in, alu_src_in} = 30'h0;
        alu_op_in = CSR_OP_NONE;
        errors = 0;
        compares = 0;
        repeat (3) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        power_rst_in = 1'b0;
        t_regs();
        t_alu();
        t_events();
        t_indirect();
        complete_run();
    end

    initial begin
        #100us;
        errors++;
        complete_run();
    end
endmodule : tb
